// >>> src/mtg_consts.svh
// Constants for the mission timing generator: clock rates, divide ratios and limits.
// Assumes it is included by every design file that needs a count or a limit.
//
// Summary of operation
// RULE1 - Locked mode slaves the internal timebase to each guidance computer sync pulse.
// RULE2 - On missing sync, switch to own oscillator with no time jump or gap.
// RULE3 - Keep elapsed time as BCD day, hour, minute and second fields for telemetry.
// RULE4 - Drive a 512 kHz square wave to the telemetry encoder and premod processor.
// RULE5 - Drive a 6.4 kHz square wave to the three power inverters.
// RULE6 - Encoder takes bit clock and frame sync, falling back on its own reference.
// RULE7 - Also give 1 pps frame sync, 10 pps timer, 10 minute pulse, 25-bit code.
`ifndef MTG_CONSTS_SVH
`define MTG_CONSTS_SVH

`define MTG_SYS_CLK_MHZ 125
`define MTG_SYNC_KHZ 1024
`define MTG_SYNC_HZ (`MTG_SYNC_KHZ * 1000)
`define MTG_NOM_PERIOD ((`MTG_SYS_CLK_MHZ * 1000) / `MTG_SYNC_KHZ)
`define MTG_PERIOD_TOL 4
`define MTG_RELOCK_PULSES 8
`define MTG_INV_HZ 6400
`define MTG_EVENT_HZ 10
`define MTG_FRAME_HZ 1
`define MTG_HALF_6K4 (`MTG_SYNC_HZ / (2 * `MTG_INV_HZ))
`define MTG_HALF_10CPS (`MTG_SYNC_HZ / (2 * `MTG_EVENT_HZ))
`define MTG_HALF_1CPS (`MTG_SYNC_HZ / (2 * `MTG_FRAME_HZ))
`define MTG_DAY_MAX 4'h9
`define MTG_MET_RESET 36'h0

`endif

// >>> src/mtg_pkg.sv
// Types shared by the mission timing generator modules.
// Assumes nothing beyond a SystemVerilog compiler.
package mtg_pkg;

  typedef enum logic [1:0] {
    MTG_HOLDOVER,
    MTG_LOCKED
  } mtg_mode_t;

  typedef struct packed {
    logic [3:0] day_h;
    logic [3:0] day_t;
    logic [3:0] day_u;
    logic [3:0] hr_t;
    logic [3:0] hr_u;
    logic [3:0] min_t;
    logic [3:0] min_u;
    logic [3:0] sec_t;
    logic [3:0] sec_u;
  } mtg_met_t;

  typedef struct packed {
    logic sq_512k;
    logic sq_6k4;
    logic sq_10;
    logic sq_1;
  } mtg_wave_t;

endpackage

// >>> src/mtg_met_counter.sv
// Elapsed time counter in BCD days, hours, minutes and seconds.
// Assumes sec_tick is a one-cycle pulse once per second from the timebase.
`include "mtg_consts.svh"

module mtg_met_counter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sec_tick,
  input wire logic load,
  input wire mtg_pkg::mtg_met_t load_value,
  output mtg_pkg::mtg_met_t met,
  output logic ten_min_pulse
);
  import mtg_pkg::*;

  mtg_met_t met_q, met_d;
  logic ten_q, ten_d;

  function automatic logic [4:0] bcd_step(input logic [3:0] dig, input logic [3:0] top,
                                          input logic en);
    logic [4:0] r;
    r = {1'b0, dig};
    if (en) begin
      if (dig >= top) begin
        r = {1'b1, 4'h0};
      end else begin
        r = {1'b0, dig + 4'h1};
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [4:0] s;
    logic c;
    logic hr_wrap;
    s = 5'h00;
    c = 1'b0;
    hr_wrap = 1'b0;
    met_d = met_q;
    ten_d = 1'b0;
    if (load) begin
      met_d = load_value;
    end else if (sec_tick) begin
      s = bcd_step(met_q.sec_u, 4'h9, 1'b1); met_d.sec_u = s[3:0]; c = s[4]; // [RULE3]
      s = bcd_step(met_q.sec_t, 4'h5, c); met_d.sec_t = s[3:0]; c = s[4];
      s = bcd_step(met_q.min_u, 4'h9, c); met_d.min_u = s[3:0]; c = s[4];
      // Every roll of the minute units digit from 9 marks ten whole minutes.
      ten_d = c; // [RULE7]
      s = bcd_step(met_q.min_t, 4'h5, c); met_d.min_t = s[3:0]; c = s[4];
      hr_wrap = c && (met_q.hr_t == 4'h2) && (met_q.hr_u == 4'h3);
      if (hr_wrap) begin
        met_d.hr_t = 4'h0;
        met_d.hr_u = 4'h0;
      end else begin
        s = bcd_step(met_q.hr_u, 4'h9, c); met_d.hr_u = s[3:0];
        if (s[4]) begin
          met_d.hr_t = met_q.hr_t + 4'h1;
        end
      end
      s = bcd_step(met_q.day_u, 4'h9, hr_wrap); met_d.day_u = s[3:0]; c = s[4];
      s = bcd_step(met_q.day_t, 4'h9, c); met_d.day_t = s[3:0]; c = s[4];
      s = bcd_step(met_q.day_h, `MTG_DAY_MAX, c); met_d.day_h = s[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      met_q <= `MTG_MET_RESET;
      ten_q <= 1'b0;
    end else begin
      met_q <= met_d;
      ten_q <= ten_d;
    end
  end

  assign met = met_q;
  assign ten_min_pulse = ten_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_sec_carry;
    sec_tick && !load && met_q.sec_u == 4'h9 && met_q.sec_t != 4'h5
      |=> met_q.sec_u == 4'h0 && met_q.sec_t == $past(met_q.sec_t) + 4'h1;
  endproperty
  a_sec_carry: assert property (p_sec_carry) else $error("seconds carry wrong"); // [RULE3]

  property p_hold;
    !sec_tick && !load |=> $stable(met_q);
  endproperty
  a_hold: assert property (p_hold) else $error("elapsed time moved without tick"); // [RULE3]

  property p_ten_min;
    ten_q |-> met_q.min_u == 4'h0 && met_q.sec_t == 4'h0 && met_q.sec_u == 4'h0;
  endproperty
  a_ten_min: assert property (p_ten_min) else $error("ten minute pulse misplaced"); // [RULE7]
endmodule

// >>> src/mtg_timing_unit.sv
// Mission timing unit: sync-locked timebase, square-wave dividers and time codes.
// Assumes the guidance computer sync pulse is a one-cycle pulse synchronous to sys_clk.
`include "mtg_consts.svh"

module mtg_timing_unit #(
  parameter int HALF_10CPS = `MTG_HALF_10CPS,
  parameter int HALF_1CPS = `MTG_HALF_1CPS,
  parameter int DIV_W = 20
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic guidance_computer_sync,
  input wire logic met_load,
  input wire mtg_pkg::mtg_met_t met_load_value,
  output mtg_pkg::mtg_wave_t waves,
  output logic frame_sync_pulse,
  output logic ten_min_pulse,
  output logic [24:0] time_code,
  output mtg_pkg::mtg_met_t elapsed_time_count,
  output logic on_own_osc
);
  import mtg_pkg::*;

  localparam logic [7:0] NOM = 8'(`MTG_NOM_PERIOD);
  localparam logic [7:0] TOL = 8'(`MTG_PERIOD_TOL);
  localparam logic [3:0] RELOCK = 4'(`MTG_RELOCK_PULSES);
  localparam int MAX_GAP = 2 * `MTG_NOM_PERIOD + 3 * `MTG_PERIOD_TOL;
  localparam int HALFS [3] = '{`MTG_HALF_6K4, HALF_10CPS, HALF_1CPS};

  mtg_mode_t mode_q, mode_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] since_q, since_d;
  logic [7:0] period_q, period_d;
  logic [3:0] good_q, good_d;
  logic tick;
  logic sq512_q, sq512_d;
  logic frame_q, frame_d;
  logic [24:0] code_q, code_d;
  logic [2:0] div_sq;
  logic [2:0] div_wrap;

  function automatic logic in_window(input logic [7:0] ival);
    return (ival >= NOM - TOL) && (ival <= NOM + TOL);
  endfunction

  // Timebase. The 1024 kHz tick follows the sync pulse while locked and the
  // local count otherwise; the local period is the last measured good interval,
  // so the changeover keeps the same rate and no tick is ever skipped.
  always_comb begin
    logic [7:0] cnt_inc;
    logic [7:0] ival;
    cnt_inc = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
    ival = (since_q == 8'hFF) ? since_q : since_q + 8'h01;
    mode_d = mode_q;
    cnt_d = cnt_inc;
    since_d = ival;
    period_d = period_q;
    good_d = good_q;
    tick = 1'b0;
    if (guidance_computer_sync) begin
      since_d = 8'h00;
    end
    case (mode_q)
      MTG_LOCKED: begin
        if (guidance_computer_sync) begin
          tick = 1'b1; // [RULE1]
          cnt_d = 8'h00;
          if (in_window(ival)) begin
            period_d = ival;
          end
        end else if (cnt_inc >= period_q + TOL) begin
          // The missing pulse is replaced by a local tick TOL cycles after it was due. [RULE2]
          tick = 1'b1;
          cnt_d = 8'h00;
          mode_d = MTG_HOLDOVER;
          good_d = 4'h0;
        end
      end
      MTG_HOLDOVER: begin
        if (cnt_inc >= period_q) begin
          tick = 1'b1; // [RULE2]
          cnt_d = 8'h00;
        end
        if (guidance_computer_sync) begin
          if (in_window(ival)) begin
            good_d = (good_q == RELOCK) ? good_q : good_q + 4'h1;
          end else begin
            good_d = 4'h0;
          end
          if (in_window(ival) && good_q + 4'h1 >= RELOCK) begin
            // Realign on the pulse; a pulse close behind a local tick only
            // restarts the count, which stretches one period but never doubles.
            mode_d = MTG_LOCKED; // [RULE1]
            period_d = ival;
            cnt_d = 8'h00;
            tick = (cnt_inc >= (period_q >> 1));
          end
        end
      end
      default: begin
        mode_d = MTG_HOLDOVER;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= MTG_HOLDOVER;
      cnt_q <= 8'h00;
      since_q <= 8'h00;
      period_q <= NOM;
      good_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      since_q <= since_d;
      period_q <= period_d;
      good_q <= good_d;
    end
  end

  // Half the sync rate for the encoder clock and the emergency key tone.
  always_comb begin
    sq512_d = tick ? ~sq512_q : sq512_q; // [RULE4]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sq512_q <= 1'b0;
    end else begin
      sq512_q <= sq512_d;
    end
  end

  // Dividers for the inverter, event timer and frame rates, all off the tick.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_div
      logic [DIV_W-1:0] dcnt_q, dcnt_d;
      logic dsq_q, dsq_d;
      logic wrap;
      always_comb begin
        dcnt_d = dcnt_q;
        dsq_d = dsq_q;
        wrap = 1'b0;
        if (tick) begin
          if (dcnt_q == DIV_W'(HALFS[g] - 1)) begin
            dcnt_d = '0;
            dsq_d = ~dsq_q; // [RULE5] [RULE7]
            wrap = 1'b1;
          end else begin
            dcnt_d = dcnt_q + 1'b1;
          end
        end
      end
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          dcnt_q <= '0;
          dsq_q <= 1'b0;
        end else begin
          dcnt_q <= dcnt_d;
          dsq_q <= dsq_d;
        end
      end
      assign div_sq[g] = dsq_q;
      assign div_wrap[g] = wrap;
    end
  endgenerate

  // Frame sync and the binary seconds code step on each rising edge of 1 pps.
  always_comb begin
    frame_d = div_wrap[2] & ~div_sq[2]; // [RULE7]
    code_d = frame_d ? code_q + 25'h0000001 : code_q;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_q <= 1'b0;
      code_q <= 25'h0000000;
    end else begin
      frame_q <= frame_d;
      code_q <= code_d;
    end
  end

  mtg_met_counter u_met (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sec_tick(frame_d),
    .load(met_load),
    .load_value(met_load_value),
    .met(elapsed_time_count),
    .ten_min_pulse(ten_min_pulse)
  );

  assign waves = '{sq_512k: sq512_q, sq_6k4: div_sq[0], sq_10: div_sq[1], sq_1: div_sq[2]};
  assign frame_sync_pulse = frame_q;
  assign time_code = code_q;
  assign on_own_osc = (mode_q != MTG_LOCKED);

  // Helper: cycles since the last tick, for the gap check.
  logic [8:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || tick) begin
      gap_q <= 9'h000;
    end else if (gap_q != 9'h1FF) begin
      gap_q <= gap_q + 9'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_lock_tick;
    mode_q == MTG_LOCKED && guidance_computer_sync |-> tick ##1 cnt_q == 8'h00;
  endproperty
  a_lock_tick: assert property (p_lock_tick) else $error("sync pulse not followed"); // [RULE1]

  property p_lost_switch;
    mode_q == MTG_LOCKED && !guidance_computer_sync && cnt_q + 8'h01 >= period_q + TOL
      |-> tick ##1 (mode_q == MTG_HOLDOVER && on_own_osc);
  endproperty
  a_lost_switch: assert property (p_lost_switch) else $error("no holdover on lost sync"); // [RULE2]

  property p_no_gap;
    gap_q <= 9'(MAX_GAP);
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("timebase tick gap too long"); // [RULE2]

  property p_512k;
    tick |=> sq512_q != $past(sq512_q);
  endproperty
  a_512k: assert property (p_512k) else $error("512k wave did not toggle"); // [RULE4]

  property p_512k_hold;
    !tick |=> $stable(sq512_q);
  endproperty
  a_512k_hold: assert property (p_512k_hold) else $error("512k wave toggled off tick"); // [RULE4]

  property p_inv;
    tick && g_div[0].dcnt_q == DIV_W'(HALFS[0] - 1) |=> $changed(waves.sq_6k4);
  endproperty
  a_inv: assert property (p_inv) else $error("inverter wave did not toggle"); // [RULE5]

  sequence s_frame;
    frame_q ##1 !frame_q;
  endsequence

  property p_frame;
    $rose(waves.sq_1) |-> s_frame;
  endproperty
  a_frame: assert property (p_frame) else $error("frame sync pulse wrong"); // [RULE7]

  property p_code;
    frame_q |-> time_code == $past(time_code) + 25'h0000001;
  endproperty
  a_code: assert property (p_code) else $error("time code did not step"); // [RULE7]
endmodule

// >>> test/mtg_sync_source.sv
// Guidance computer model: one-cycle sync pulse every period cycles.
// Assumes the bench moves en and period just after a rising sys_clk edge.
module mtg_sync_source (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic en,
  input wire logic [7:0] period,
  output logic sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // Outside enable the line rests low, so a dead computer looks like a lost pulse.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !en) begin
      cnt_q <= 8'h00;
      sync <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      sync <= (cnt_q == period - 8'h01);
    end
  end
endmodule

// >>> test/tb.sv
// Self-checking bench for the timing unit with shortened 10 pps and 1 pps dividers.
// Assumes the sync source model beside it and the design package.
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); err_count++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mtg_pkg::*;
  typedef struct {mtg_met_t ld; mtg_met_t ex; logic tm;} mtg_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sync_en = 1'b0;
  logic sync;
  logic met_load = 1'b0;
  mtg_met_t met_load_value = 36'h000000000;
  mtg_wave_t waves;
  logic frame_sync_pulse;
  logic ten_min_pulse;
  logic [24:0] time_code;
  mtg_met_t elapsed_time_count;
  logic on_own_osc;
  int err_count = 0;
  int total_checks = 0;
  mtg_row_t rows[6] = '{
    '{36'h000000000, 36'h000000001, 1'b0}, '{36'h000000059, 36'h000000100, 1'b0},
    '{36'h000000959, 36'h000001000, 1'b1}, '{36'h000235959, 36'h001000000, 1'b1},
    '{36'h999235959, 36'h000000000, 1'b1}, '{36'h012095959, 36'h012100000, 1'b1}};
  int gaps[4] = '{1952, 976, 19520, 244};
  mtg_sync_source src (.sys_clk(sys_clk), .sys_rst(sys_rst), .en(sync_en),
    .period(8'h7A), .sync(sync));
  mtg_timing_unit #(.HALF_10CPS(4), .HALF_1CPS(8)) DUT (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .guidance_computer_sync(sync), .met_load(met_load),
    .met_load_value(met_load_value), .waves(waves), .frame_sync_pulse(frame_sync_pulse),
    .ten_min_pulse(ten_min_pulse), .time_code(time_code),
    .elapsed_time_count(elapsed_time_count), .on_own_osc(on_own_osc));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Every wait is bounded; running out of cycles ends the run as a failure.
  task automatic step(inout int n);
    @(posedge sys_clk);
    #1;
    n++;
    if (n > 50000) begin
      $display("[ERR] timeout exp wait got none");
      err_count++;
      end_of_test();
    end
  endtask
  // The bench stands where the encoder would, taking its frame sync from the unit.
  task automatic wait_frame(output logic tm);
    int n;
    n = 0;
    tm = 1'b0;
    while (frame_sync_pulse !== 1'b1) begin
      step(n);
      tm = tm | (ten_min_pulse === 1'b1);
    end
  endtask
  task automatic rise_gap(input int b, output int gap);
    int n;
    n = 0;
    while (waves[b] !== 1'b0) step(n);
    while (waves[b] !== 1'b1) step(n);
    gap = 0;
    while (waves[b] !== 1'b0) step(gap);
    while (waves[b] !== 1'b1) step(gap);
  endtask
  initial begin
    int n;
    int g;
    logic tm;
    logic [24:0] tc;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("waves", 4'h0, waves)
    `CHK("elapsed", 36'h000000000, elapsed_time_count)
    `CHK("time_code", 25'h0000000, time_code)
    `CHK("own_osc", 1'b1, on_own_osc)
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    sync_en <= 1'b1;
    n = 0;
    while (on_own_osc !== 1'b0 && n < 2000) step(n);
    `CHK("locked", 1'b0, on_own_osc)
    for (int b = 0; b < 4; b++) begin
      rise_gap(b, g);
      `CHK("wave_gap", gaps[b], g)
    end
    foreach (rows[i]) begin
      wait_frame(tm);
      tc = time_code;
      @(posedge sys_clk);
      met_load <= 1'b1;
      met_load_value <= rows[i].ld;
      @(posedge sys_clk);
      met_load <= 1'b0;
      #1;
      `CHK("loaded", rows[i].ld, elapsed_time_count)
      wait_frame(tm);
      for (int k = 0; k < 2; k++) begin
        @(posedge sys_clk);
        #1;
        tm = tm | (ten_min_pulse === 1'b1);
      end
      `CHK("elapsed", rows[i].ex, elapsed_time_count)
      `CHK("ten_min", rows[i].tm, tm)
      `CHK("time_code", tc + 25'h0000001, time_code)
    end
    wait_frame(tm);
    tc = time_code;
    @(posedge sys_clk);
    sync_en <= 1'b0;
    n = 0;
    while (on_own_osc !== 1'b1 && n < 140) step(n);
    `CHK("holdover", 1'b1, on_own_osc)
    rise_gap(3, g);
    `CHK("hold_gap", 244, g)
    wait_frame(tm);
    `CHK("hold_tc", tc + 25'h0000001, time_code)
    // A reset in mid-run must clear the counts and restart on the nominal period.
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("rst_waves", 4'h0, waves)
    `CHK("rst_elapsed", 36'h000000000, elapsed_time_count)
    `CHK("rst_code", 25'h0000000, time_code)
    `CHK("rst_osc", 1'b1, on_own_osc)
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rise_gap(3, g);
    `CHK("rst_gap", 244, g)
    `CHK("rst_frame", 1'b0, frame_sync_pulse)
    end_of_test();
  end
endmodule
